// ### hw/rmc_consts.vh
// constants for the rectifier management control block
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH
`define RMC_CLK_MHZ        125
`define RMC_STRETCH_MAX_MS 25
`define RMC_ADDR_BASE      4'hB
`define RMC_SENSE_WP_MV    12'h3E8
`define RMC_SLOT_T0        12'h899
`define RMC_SLOT_T1        12'h630
`define RMC_SLOT_T2        12'h3B5
`define RMC_SHELF_T1       12'hB9A
`define RMC_SHELF_T2       12'hA00
`define RMC_SHELF_T3       12'h85C
`define RMC_SHELF_T4       12'h6A4
`define RMC_SHELF_T5       12'h4E2
`define RMC_SHELF_T6       12'h320
`define RMC_SHELF_T7       12'h0FA
`define RMC_CMD_CLEAR      8'h03
`define RMC_CMD_VSET       8'h21
`define RMC_CMD_STATUS     8'h79
`define RMC_LEN_CLEAR      3'h3
`define RMC_LEN_VSET       3'h4
`define RMC_VSET_MAX       8'hE8
`define RMC_CRC_POLY       8'h07
`define RMC_ST_RESTART     5
`define RMC_ST_COMM        6
`define RMC_ST_CHANGED     7
`define RMC_PIN_IDLE       9'h1FF
`endif

// ### hw/rmc_top.v
// rectifier control pins, strap decode, status/alert and dual-channel management slave
`timescale 1ns/100ps
`include "rmc_consts.vh"

// How it works
// RULE_01 - output on only while enable request low
// RULE_02 - seat detect also gates output on
// RULE_03 - trim sets setpoint until software override
// RULE_04 - sense above 1V enables write protect
// RULE_05 - selector reset pin restores default channel
// RULE_06 - slot strap decodes to A1 A0
// RULE_07 - shelf level decodes to A2 parity
// RULE_08 - line rating flag follows input line
// RULE_09 - loss warning high while output delivered
// RULE_10 - fault output low on listed failures
// RULE_11 - status follows present condition continuously
// RULE_12 - communication errors held until clear faults
// RULE_13 - change bit set on status change
// RULE_14 - auto restart after over-voltage, flag restart
// RULE_15 - successful status read clears non-comm status
// RULE_16 - two independent channels, one selected
// RULE_17 - selector starts on channel zero
// RULE_18 - masters tolerate channel switch mid-transfer
// RULE_19 - device is slave, never clocks bus
// RULE_20 - clock stretch bounded by maximum interval
// RULE_21 - host waits out held clock
// RULE_22 - stretch only after ninth acknowledge bit
// RULE_23 - trailing CRC-8 checked, missing one ignored; here a write without its CRC byte is dropped, not run
// RULE_24 - alert latched low until read, clear, recycle
// RULE_25 - 100kHz and 400kHz clocks both served
module rmc_top #(
    parameter [21:0] STRETCH_MAX_CYC = `RMC_STRETCH_MAX_MS * `RMC_CLK_MHZ * 1000
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        remote_on_n,
    input  wire        seat_detect_pin_n,
    input  wire        selector_reset_n,
    input  wire        take_ch0_n,
    input  wire        take_ch1_n,
    input  wire [7:0]  trim_code,
    input  wire [11:0] sense_mv,
    input  wire [11:0] slot_mv,
    input  wire [11:0] shelf_mv,
    input  wire        high_line,
    input  wire        decay_warn,
    input  wire        fan_fail,
    input  wire        ot_warn,
    input  wire        ot_shut,
    input  wire        ov_trip,
    input  wire        int_fault,
    input  wire        auto_restart_en,
    input  wire        ctl_busy,
    input  wire        scl0_i,
    output wire        scl0_o,
    output wire        scl0_oe_n,
    input  wire        sda0_i,
    output wire        sda0_o,
    output wire        sda0_oe_n,
    input  wire        scl1_i,
    output wire        scl1_o,
    output wire        scl1_oe_n,
    input  wire        sda1_i,
    output wire        sda1_o,
    output wire        sda1_oe_n,
    output wire        alert_oe_n,
    output reg         out_on_q,
    output reg  [7:0]  setpoint_q,
    output reg         nv_wp_q,
    output reg  [2:0]  addr_q,
    output reg         power_cap_q,
    output reg         pfw_q,
    output reg         fault_n_q,
    output reg         sel_q,
    output wire [7:0]  status
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_RX    = 3'h1;
    localparam [2:0] ST_RXACK = 3'h2;
    localparam [2:0] ST_TX    = 3'h3;
    localparam [2:0] ST_TXACK = 3'h4;

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] b;
        integer     i;
        reg   [7:0] r;
        begin
            r = c ^ b;
            for (i = 0; i < 8; i = i + 1)
                r = r[7] ? ((r << 1) ^ `RMC_CRC_POLY) : (r << 1);
            crc8 = r;
        end
    endfunction

    reg  [8:0]  a1_q;
    reg  [8:0]  a2_q;
    reg  [43:0] w1_q;
    reg  [43:0] w2_q;
    reg         scl_p_q;
    reg         sda_p_q;
    reg  [2:0]  st_q;
    reg  [3:0]  bit_q;
    reg  [7:0]  sh_q;
    reg  [2:0]  idx_q;
    reg  [7:0]  cmd_q;
    reg  [7:0]  dat_q;
    reg  [7:0]  crc_q;
    reg         adr_q;
    reg         rd_q;
    reg         txn_q;
    reg         mack_q;
    reg         sda_drv_q;
    reg         stretch_q;
    reg  [21:0] scnt_q;
    reg         done_rd_q;
    reg         clr_q;
    reg         vset_q;
    reg         pec_bad_q;
    reg         cmd_bad_q;
    reg  [4:0]  al_q;
    reg         restart_q;
    reg         pec_err_q;
    reg         cmd_err_q;
    reg         chg_q;
    reg  [6:0]  prev_q;
    reg         alert_q;
    reg         ovblk_q;
    reg         ovr_q;
    reg  [2:0]  exp_len;
    reg         sel_d;

    // 2-flop synchronisers for pins and slow converter codes
    wire        rem_n   = a2_q[0];
    wire        seat_n  = a2_q[1];
    wire        srst_n  = a2_q[2];
    wire        tk0_n   = a2_q[3];
    wire        tk1_n   = a2_q[4];
    wire [7:0]  trim_s  = w2_q[7:0];
    wire [11:0] sense_s = w2_q[19:8];
    wire [11:0] slot_s  = w2_q[31:20];
    wire [11:0] shelf_s = w2_q[43:32];
    // selected channel only; the other is left alone
    wire        scl_m   = sel_q ? a2_q[7] : a2_q[5]; // RULE_16
    wire        sda_m   = sel_q ? a2_q[8] : a2_q[6]; // RULE_16
    // edges found at the system rate serve either bus speed
    wire        scl_rise = scl_m & ~scl_p_q;         // RULE_25
    wire        scl_fall = ~scl_m & scl_p_q;
    wire        start    = scl_m & scl_p_q & sda_p_q & ~sda_m;
    wire        stop     = scl_m & scl_p_q & ~sda_p_q & sda_m;
    wire        chan_sw  = sel_d != sel_q;
    wire [6:0]  my_addr  = {`RMC_ADDR_BASE, addr_q};
    wire        req      = ~rem_n & ~seat_n;         // RULE_01 RULE_02
    wire [4:0]  live     = {int_fault, ov_trip, ot_shut, ot_warn, fan_fail};
    wire [6:0]  body     = {pec_err_q | cmd_err_q, restart_q, al_q};
    wire        changed  = body != prev_q;
    wire        on_d     = req & ~ovblk_q & ~ov_trip;
    wire        recycle  = on_d & ~out_on_q;
    wire        vset_ok  = vset_q & (dat_q <= `RMC_VSET_MAX);
    wire        restart_ev = ovblk_q & ~ov_trip & auto_restart_en;
    wire [2:0]  lvl = {2'h0, shelf_s <= `RMC_SHELF_T1} + {2'h0, shelf_s <= `RMC_SHELF_T2}
                    + {2'h0, shelf_s <= `RMC_SHELF_T3} + {2'h0, shelf_s <= `RMC_SHELF_T4}
                    + {2'h0, shelf_s <= `RMC_SHELF_T5} + {2'h0, shelf_s <= `RMC_SHELF_T6}
                    + {2'h0, shelf_s <= `RMC_SHELF_T7};

    assign status     = {chg_q, body};
    // bus pins are pulled low only, never driven high
    assign scl0_o     = 1'b0;
    assign scl1_o     = 1'b0;
    assign sda0_o     = 1'b0;
    assign sda1_o     = 1'b0;
    assign scl0_oe_n  = ~(~sel_q & stretch_q);      // RULE_19
    assign scl1_oe_n  = ~(sel_q & stretch_q);       // RULE_19
    assign sda0_oe_n  = ~(~sel_q & sda_drv_q);
    assign sda1_oe_n  = ~(sel_q & sda_drv_q);
    assign alert_oe_n = ~alert_q;                   // RULE_24

    always @*
    begin
        sel_d = sel_q;
        if (~srst_n || ~tk0_n)
            sel_d = 1'b0;                           // RULE_05
        else if (~tk1_n)
            sel_d = 1'b1;
        case (cmd_q)
            `RMC_CMD_CLEAR: exp_len = `RMC_LEN_CLEAR;
            `RMC_CMD_VSET:  exp_len = `RMC_LEN_VSET;
            default:        exp_len = 3'h0;
        endcase
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            a1_q    <= `RMC_PIN_IDLE;
            a2_q    <= `RMC_PIN_IDLE;
            w1_q    <= 44'h0;
            w2_q    <= 44'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sel_q   <= 1'b0;                        // RULE_17
        end
        else
        begin
            a1_q    <= {sda1_i, scl1_i, sda0_i, scl0_i, take_ch1_n, take_ch0_n,
                        selector_reset_n, seat_detect_pin_n, remote_on_n};
            a2_q    <= a1_q;
            w1_q    <= {shelf_mv, slot_mv, sense_mv, trim_code};
            w2_q    <= w1_q;
            scl_p_q <= scl_m;
            sda_p_q <= sda_m;
            sel_q   <= sel_d;
        end
    end

    // slave byte engine
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;  bit_q <= 4'h0;  sh_q <= 8'h00;  idx_q <= 3'h0;
            cmd_q <= 8'h00;   dat_q <= 8'h00; crc_q <= 8'h00; adr_q <= 1'b0;
            rd_q <= 1'b0;     txn_q <= 1'b0;  mack_q <= 1'b0; sda_drv_q <= 1'b0;
            done_rd_q <= 1'b0; clr_q <= 1'b0; vset_q <= 1'b0;
            pec_bad_q <= 1'b0; cmd_bad_q <= 1'b0;
        end
        else
        begin
            done_rd_q <= 1'b0;
            clr_q     <= 1'b0;
            vset_q    <= 1'b0;
            pec_bad_q <= 1'b0;
            cmd_bad_q <= 1'b0;
            if (chan_sw)
            begin
                st_q      <= ST_IDLE;               // RULE_18
                sda_drv_q <= 1'b0;
                rd_q      <= 1'b0;
            end
            else if (start)
            begin
                if (st_q == ST_IDLE)
                begin
                    idx_q <= 3'h0;
                    crc_q <= 8'h00;
                end
                st_q      <= ST_RX;
                bit_q     <= 4'h0;
                adr_q     <= 1'b1;
                sda_drv_q <= 1'b0;
            end
            else if (stop)
            begin
                // a write runs only with its trailing check byte
                if (st_q != ST_IDLE && !rd_q && idx_q == exp_len && exp_len != 3'h0)
                begin
                    if (crc_q != 8'h00)
                        pec_bad_q <= 1'b1;          // RULE_23
                    else if (cmd_q == `RMC_CMD_CLEAR)
                        clr_q <= 1'b1;
                    else
                        vset_q <= 1'b1;
                end
                st_q      <= ST_IDLE;
                rd_q      <= 1'b0;
                sda_drv_q <= 1'b0;
            end
            else
            begin
                case (st_q)
                    ST_RX:
                        if (scl_rise)
                        begin
                            sh_q  <= {sh_q[6:0], sda_m};
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (scl_fall && bit_q == 4'h8)
                        begin
                            crc_q     <= crc8(crc_q, sh_q); // RULE_23
                            idx_q     <= (idx_q == 3'h7) ? idx_q : idx_q + 3'h1;
                            st_q      <= ST_RXACK;
                            sda_drv_q <= 1'b1;
                            if (adr_q)
                            begin
                                adr_q <= 1'b0;
                                if (sh_q[7:1] != my_addr)
                                begin
                                    st_q      <= ST_IDLE;
                                    sda_drv_q <= 1'b0;
                                end
                                else if (sh_q[0])
                                begin
                                    if (idx_q == 3'h2 && cmd_q == `RMC_CMD_STATUS)
                                        rd_q <= 1'b1;
                                    else
                                    begin
                                        st_q      <= ST_IDLE;
                                        sda_drv_q <= 1'b0;
                                    end
                                end
                            end
                            else if (idx_q == 3'h1)
                            begin
                                cmd_q     <= sh_q;
                                cmd_bad_q <= sh_q != `RMC_CMD_CLEAR && sh_q != `RMC_CMD_VSET
                                             && sh_q != `RMC_CMD_STATUS;
                            end
                            else if (idx_q == 3'h2)
                                dat_q <= sh_q;
                        end
                    ST_RXACK:
                        if (scl_fall)
                        begin
                            bit_q <= 4'h0;
                            if (rd_q)
                            begin
                                st_q      <= ST_TX;
                                txn_q     <= 1'b0;
                                sh_q      <= {status[6:0], 1'b0};
                                sda_drv_q <= ~status[7];
                                crc_q     <= crc8(crc_q, status);
                            end
                            else
                            begin
                                st_q      <= ST_RX;
                                sda_drv_q <= 1'b0;
                            end
                        end
                    ST_TX:
                        if (scl_fall)
                        begin
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7)
                            begin
                                st_q      <= ST_TXACK;
                                sda_drv_q <= 1'b0;
                            end
                            else
                            begin
                                sda_drv_q <= ~sh_q[7];
                                sh_q      <= {sh_q[6:0], 1'b0};
                            end
                        end
                    ST_TXACK:
                        if (scl_rise)
                            mack_q <= ~sda_m;
                        else if (scl_fall)
                        begin
                            bit_q <= 4'h0;
                            if (txn_q)
                            begin
                                done_rd_q <= 1'b1;  // RULE_15
                                st_q      <= ST_IDLE;
                            end
                            else if (mack_q)
                            begin
                                st_q      <= ST_TX;
                                txn_q     <= 1'b1;
                                sh_q      <= {crc_q[6:0], 1'b0};
                                sda_drv_q <= ~crc_q[7];
                            end
                            else
                                st_q <= ST_IDLE;
                        end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // clock stretch at the end of the ninth bit, bounded
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stretch_q <= 1'b0;
            scnt_q    <= 22'h0;
        end
        else if (chan_sw)
            stretch_q <= 1'b0;
        else if (stretch_q)
        begin
            scnt_q <= scnt_q + 22'h1;
            if (!ctl_busy || scnt_q == STRETCH_MAX_CYC - 22'h1)
                stretch_q <= 1'b0;                  // RULE_20
        end
        else if (st_q == ST_RXACK && scl_fall && ctl_busy && !start && !stop)
        begin
            stretch_q <= 1'b1;                      // RULE_22
            scnt_q    <= 22'h0;
        end
    end

    // status, alert, output control and pins
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            al_q <= 5'h00;      restart_q <= 1'b0; pec_err_q <= 1'b0;
            cmd_err_q <= 1'b0;  chg_q <= 1'b0;     prev_q <= 7'h00;
            alert_q <= 1'b0;    ovblk_q <= 1'b0;   out_on_q <= 1'b0;
            ovr_q <= 1'b0;      setpoint_q <= 8'h00; nv_wp_q <= 1'b0;
            addr_q <= 3'h0;     power_cap_q <= 1'b0; pfw_q <= 1'b0;
            fault_n_q <= 1'b1;
        end
        else
        begin
            al_q      <= live; // RULE_11
            restart_q <= (restart_q & ~(done_rd_q | clr_q)) | restart_ev;  // RULE_14 RULE_15
            pec_err_q <= (pec_err_q & ~clr_q) | pec_bad_q;                 // RULE_12
            cmd_err_q <= (cmd_err_q & ~clr_q) | cmd_bad_q | (vset_q & ~vset_ok); // RULE_12
            prev_q    <= {body[6] & ~clr_q, body[5] & ~(done_rd_q | clr_q), body[4:0]};
            chg_q     <= (chg_q & ~done_rd_q) | changed;                   // RULE_13
            alert_q   <= (alert_q & ~(done_rd_q | clr_q | recycle))
                         | changed | (clr_q & |live);                      // RULE_24
            if (ov_trip)
                ovblk_q <= 1'b1;
            else if (auto_restart_en || !req)
                ovblk_q <= 1'b0;                    // RULE_14
            out_on_q  <= on_d;                      // RULE_01 RULE_02
            if (vset_ok)
            begin
                setpoint_q <= dat_q;                // RULE_03
                ovr_q      <= 1'b1;
            end
            else if (!ovr_q)
                setpoint_q <= trim_s;               // RULE_03
            nv_wp_q     <= sense_s > `RMC_SENSE_WP_MV;     // RULE_04
            addr_q[1:0] <= (slot_s >= `RMC_SLOT_T0) ? 2'h0 :
                           (slot_s >= `RMC_SLOT_T1) ? 2'h1 :
                           (slot_s >= `RMC_SLOT_T2) ? 2'h2 : 2'h3; // RULE_06
            addr_q[2]   <= lvl[0];                  // RULE_07
            power_cap_q <= high_line;               // RULE_08
            pfw_q       <= out_on_q & ~decay_warn;  // RULE_09
            fault_n_q   <= ~(fan_fail | ot_warn | ot_shut | ov_trip | int_fault); // RULE_10
        end
    end
endmodule

// ### verification/rmc_chk.sv
// port checker for the rectifier management control block
`timescale 1ns/100ps
module rmc_chk #(
    parameter [21:0] STRETCH_MAX_CYC = 22'h32
) (
    input wire        sys_clk,
    input wire        rst,
    input wire        remote_on_n,
    input wire        seat_detect_pin_n,
    input wire        selector_reset_n,
    input wire [11:0] sense_mv,
    input wire        high_line,
    input wire        decay_warn,
    input wire        fan_fail,
    input wire        ot_warn,
    input wire        ot_shut,
    input wire        ov_trip,
    input wire        int_fault,
    input wire        scl0_o,
    input wire        sda0_o,
    input wire        scl0_oe_n,
    input wire        scl1_oe_n,
    input wire        alert_oe_n,
    input wire        out_on_q,
    input wire        nv_wp_q,
    input wire        power_cap_q,
    input wire        pfw_q,
    input wire        fault_n_q,
    input wire        sel_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    reg [21:0] low_cnt_q;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            low_cnt_q <= 22'h0;
        else if (!scl0_oe_n || !scl1_oe_n)
            low_cnt_q <= low_cnt_q + 22'h1;
        else
            low_cnt_q <= 22'h0;
    end
    property p_req_off;
        remote_on_n [*5] |-> !out_on_q;
    endproperty
    a_req_off: assert property (p_req_off) else $error("output on without request");
    property p_seat_off;
        seat_detect_pin_n [*5] |-> !out_on_q;
    endproperty
    a_seat_off: assert property (p_seat_off) else $error("output on while unseated");
    property p_wp;
        (sense_mv > 12'h3E8) [*5] |-> nv_wp_q;
    endproperty
    a_wp: assert property (p_wp) else $error("write protect missing");
    property p_sel_rst;
        !selector_reset_n [*5] |-> !sel_q;
    endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("selector not reset");
    property p_line;
        1'b1 |=> power_cap_q == $past(high_line);
    endproperty
    a_line: assert property (p_line) else $error("line rating flag wrong");
    property p_pfw;
        decay_warn [*2] |=> !pfw_q;
    endproperty
    a_pfw: assert property (p_pfw) else $error("loss warning not low");
    property p_fault;
        (fan_fail || ot_warn || ot_shut || ov_trip || int_fault) |=> !fault_n_q;
    endproperty
    a_fault: assert property (p_fault) else $error("fault output not low");
    property p_sel_boot;
        $fell(rst) |-> !sel_q;
    endproperty
    a_sel_boot: assert property (p_sel_boot) else $error("selector not on channel 0");
    property p_slave;
        scl0_o == 1'b0 && sda0_o == 1'b0 && (scl0_oe_n || scl1_oe_n);
    endproperty
    a_slave: assert property (p_slave) else $error("line driven high");
    property p_stretch;
        low_cnt_q <= STRETCH_MAX_CYC + 22'h1;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock stretch too long");
    c_on: cover property ($rose(out_on_q));
    c_sel: cover property ($rose(sel_q));
    c_stretch: cover property (low_cnt_q == 22'h5);
    c_alert: cover property ($rose(alert_oe_n));
endmodule

// ### verification/rmc_host.sv
// i2c host controller model on one open-drain channel
`timescale 1ns/100ps
module rmc_host #(
    parameter HALF = 80
) (
    output logic scl_pull,
    output logic sda_pull,
    input  wire  scl,
    input  wire  sda
);
    logic hung = 1'b0;
    initial {scl_pull, sda_pull} = 2'b00;
    task wait_hi;
        int n;
        n = 0;
        while (!scl && n < 4000)
        begin
            #8;
            n++;
        end
        hung = hung | !scl;
    endtask
    task clk(input logic a, input logic b, input logic keep_hi, output logic v);
        #21;
        sda_pull = !a;
        #(HALF - 21);
        scl_pull = 1'b0;
        wait_hi();
        #HALF;
        v = sda;
        sda_pull = !b;
        #21;
        scl_pull = !keep_hi;
    endtask
    task xfer(input logic [7:0] d, input logic n, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            clk(d[i], d[i], 1'b0, r[i]);
        clk(n, n, 1'b0, a);
    endtask
endmodule

// ### verification/tb_rectifier_mgmt_control_interface.sv
// self-checking bench for the rectifier management control block
`timescale 1ns/100ps
`include "rmc_consts.vh"
module tb_rectifier_mgmt_control_interface;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        remote_on_n, seat_detect_pin_n, selector_reset_n, take_ch0_n, take_ch1_n;
    logic        high_line, decay_warn, fan_fail, ot_warn, ot_shut, ov_trip, int_fault;
    logic        auto_restart_en, ctl_busy, ch, a;
    logic [7:0]  trim_code, aw, v, tx[$];
    logic [11:0] sense_mv, slot_mv, shelf_mv;
    wire         h0c, h0d, h1c, h1d, scl0_o, scl0_oe_n, sda0_o, sda0_oe_n, scl1_o;
    wire         scl1_oe_n, sda1_o, sda1_oe_n, alert_oe_n, out_on_q, nv_wp_q;
    wire         power_cap_q, pfw_q, fault_n_q, sel_q;
    wire [7:0]   setpoint_q, status;
    wire [2:0]   addr_q;
    wire         scl0_i = !h0c && (scl0_oe_n || scl0_o);
    wire         sda0_i = !h0d && (sda0_oe_n || sda0_o);
    wire         scl1_i = !h1c && (scl1_oe_n || scl1_o);
    wire         sda1_i = !h1d && (sda1_oe_n || sda1_o);
    int          bad_count = 0, num_checks = 0;
    int          shelf_t[7] = '{2970, 2560, 2140, 1700, 1250, 800, 250};
    always #4 sys_clk = ~sys_clk;
    rmc_top #(.STRETCH_MAX_CYC(22'h32)) dut (.*);
    rmc_host h0 (.scl_pull(h0c), .sda_pull(h0d), .scl(scl0_i), .sda(sda0_i));
    rmc_host h1 (.scl_pull(h1c), .sda_pull(h1d), .scl(scl1_i), .sda(sda1_i));
    task cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t %h not %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
        c = c ^ b;
        repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        return c;
    endfunction
    function automatic logic [2:0] addr_of(input int s, input int h);
        int lvl;
        lvl = 1;
        foreach (shelf_t[i]) if (h <= shelf_t[i]) lvl++;
        return {lvl % 2 == 0, s >= 2201 ? 2'h0 : s >= 1584 ? 2'h1 : s >= 949 ? 2'h2 : 2'h3};
    endfunction
    task xb(input logic [7:0] d, input logic n, output logic [7:0] r, output logic k);
        if (ch)
            h1.xfer(d, n, r, k);
        else
            h0.xfer(d, n, r, k);
    endtask
    task edge_cond(input logic b, input logic c);
        if (ch)
            h1.clk(b, c, c, a);
        else
            h0.clk(b, c, c, a);
    endtask
    task wmsg(input logic [7:0] flip);
        logic [7:0] c, r;
        c = 8'h00;
        edge_cond(1'b1, 1'b0);
        foreach (tx[i])
        begin
            xb(tx[i], 1'b1, r, a);
            chk(a, 1'b0);
            c = crc(c, tx[i]);
        end
        xb(c ^ flip, 1'b1, r, a);
        edge_cond(1'b0, 1'b1);
    endtask
    task rd_status(input logic [7:0] exp);
        logic [7:0] r, p;
        edge_cond(1'b1, 1'b0);
        xb(aw, 1'b1, r, a);
        xb(`RMC_CMD_STATUS, 1'b1, r, a);
        edge_cond(1'b1, 1'b0);
        xb(aw | 8'h01, 1'b1, r, a);
        xb(8'hFF, 1'b0, r, a);
        xb(8'hFF, 1'b1, p, a);
        edge_cond(1'b0, 1'b1);
        chk(r, exp);
        chk(p, crc(crc(crc(crc(8'h00, aw), `RMC_CMD_STATUS), aw | 8'h01), exp));
    endtask
    initial
    begin
        #600000;
        bad_count++;
        final_report();
    end
    initial
    begin
        {remote_on_n, seat_detect_pin_n, selector_reset_n, take_ch0_n, take_ch1_n} = 5'h1F;
        {high_line, decay_warn, fan_fail, ot_warn, ot_shut, ov_trip, int_fault} = 7'h00;
        {auto_restart_en, ctl_busy, ch, trim_code} = 11'h040;
        {sense_mv, slot_mv, shelf_mv} = {12'h1F4, 12'h9C4, 12'hCE4};
        void'($urandom(49028));
        cyc(12);
        rst = 1'b0;
        chk(out_on_q, 1'b0);
        chk(sel_q, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            slot_mv = 12'($urandom % 3300);
            shelf_mv = 12'($urandom % 3400);
            sense_mv = 12'(995 + $urandom % 10);
            cyc(6);
            chk(addr_q, addr_of(slot_mv, shelf_mv));
            chk(nv_wp_q, sense_mv > 1000);
        end
        chk(setpoint_q, trim_code);
        aw = {`RMC_ADDR_BASE, addr_of(slot_mv, shelf_mv), 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            {seat_detect_pin_n, remote_on_n} = 2'(8'hE1 >> (i * 2 % 8));
            cyc(6);
            chk(out_on_q, !seat_detect_pin_n && !remote_on_n);
        end
        chk(pfw_q, 1'b1);
        decay_warn = 1'b1;
        cyc(3);
        chk(pfw_q, 1'b0);
        decay_warn = 1'b0;
        auto_restart_en = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            {fan_fail, ot_warn, ot_shut, ov_trip, int_fault} = 5'h10 >> i;
            high_line = i[0];
            cyc(3);
            chk(fault_n_q, 1'b0);
            chk(power_cap_q, high_line);
            chk(alert_oe_n, 1'b0);
            chk(out_on_q, !ov_trip);
            {fan_fail, ot_warn, ot_shut, ov_trip, int_fault} = 5'h00;
            cyc(3);
            chk(fault_n_q, 1'b1);
        end
        chk(out_on_q, 1'b1);
        rd_status(8'hA0);
        cyc(3);
        chk(status, 8'h00);
        chk(alert_oe_n, 1'b1);
        tx = '{aw, `RMC_CMD_VSET, 8'hA0};
        wmsg(8'h01);
        cyc(3);
        chk(setpoint_q, trim_code);
        rd_status(8'hC0);
        cyc(3);
        chk(status, 8'h40);
        tx = '{aw, `RMC_CMD_CLEAR};
        wmsg(8'h00);
        cyc(3);
        chk(status[6], 1'b0);
        ctl_busy = 1'b1;
        v = 8'($urandom % 233);
        tx = '{aw, `RMC_CMD_VSET, v};
        wmsg(8'h00);
        ctl_busy = 1'b0;
        trim_code = 8'h11;
        cyc(6);
        chk(setpoint_q, v);
        take_ch1_n = 1'b0;
        cyc(5);
        take_ch1_n = 1'b1;
        chk(sel_q, 1'b1);
        {ch, v} = 9'h15A;
        tx = '{aw, `RMC_CMD_VSET, v};
        wmsg(8'h00);
        cyc(3);
        chk(setpoint_q, v);
        selector_reset_n = 1'b0;
        cyc(6);
        selector_reset_n = 1'b1;
        chk(sel_q, 1'b0);
        chk(h0.hung | h1.hung, 1'b0);
        final_report();
    end
endmodule
bind rmc_top rmc_chk #(.STRETCH_MAX_CYC(STRETCH_MAX_CYC)) u_chk (.*);
